// ==== hw/imu_defines.svh ====
// Register offsets, field positions, reset values and opcodes of the multiply unit
`ifndef IMU_DEFINES_SVH
`define IMU_DEFINES_SVH

// Register byte offsets
`define IMU_CTRL_OFFS       8'h00
`define IMU_FIXEXC_OFFS     8'h04
`define IMU_CONDZ_OFFS      8'h08
`define IMU_LOWPROD_OFFS    8'h0c
`define IMU_INTSTAT_OFFS    8'h10
`define IMU_INTEN_OFFS      8'h14
`define IMU_INTCLR_OFFS     8'h18
`define IMU_OPCOUNT_OFFS    8'h1c

// Control fields
`define IMU_CTRL_NEWER_BIT  0

// Fixed exception flag positions
`define IMU_FX_CARRY_BIT    0
`define IMU_FX_OVF_BIT      1
`define IMU_FX_SUMOVF_BIT   2

// Condition field zero positions
`define IMU_CZ_SUMOVF_BIT   0
`define IMU_CZ_EQUAL_BIT    1
`define IMU_CZ_GREATER_BIT  2
`define IMU_CZ_LESS_BIT     3

// Interrupt status positions
`define IMU_INT_ILLEGAL_BIT 0
`define IMU_INT_OVF_BIT     1

// Reset values
`define IMU_CTRL_RST        1'h0
`define IMU_FIXEXC_RST      3'h0
`define IMU_CONDZ_RST       4'h0
`define IMU_LOWPROD_RST     32'h0000_0000
`define IMU_INT_RST         2'h0

// Instruction encoding
`define IMU_PRIMARY_OPC     6'h1f
`define IMU_XO_FULLWORD     9'h06b
`define IMU_XO_HIGHWORD     9'h04b
`define IMU_XO_HIGHDBL      9'h049
`define IMU_XO_HIGHDBLU     9'h009

// AXI responses
`define IMU_RESP_OKAY       2'h0
`define IMU_RESP_SLVERR     2'h2

`endif

// ==== hw/imu_integer_multiply_unit.sv ====
// Integer multiply execution unit with AXI4-Lite control and status registers
// Summary of operation
// RULE1 - Full word multiply: upper product half to destination, lower half to low product register.
// RULE2 - With overflow enable, set summary and overflow flags when product exceeds 32 bits.
// RULE3 - Full word multiply never touches the carry flag.
// RULE4 - Full word record: compare low product register with zero, copy summary overflow.
// RULE5 - Overflow enable 0 keeps exception flags; record 0 keeps condition field zero.
// RULE6 - Full word multiply accepted only on the older architecture variant.
// RULE7 - Primary opcode 31; extended 107 is full word, 75 is high word; bit 31 records.
// RULE8 - Extended 73 signed and 9 unsigned high doubleword; bit 21 zero; bit 31 records.
// RULE9 - Signed high doubleword: upper 64 bits of signed 128-bit product to destination.
// RULE10 - Unsigned high doubleword: upper 64 bits of unsigned product to destination.
// RULE11 - Unsigned high doubleword record compares the result signed against zero.
// RULE12 - Unsigned high doubleword record updates all four bits, otherwise field kept.
// RULE13 - High doubleword forms are illegal on a 32-bit implementation.
// RULE14 - Signed high word: upper 32 bits of signed 64-bit product to destination.
// RULE15 - High word record compares result with zero and copies summary overflow.
// RULE16 - High word multiply accepted only on the newer architecture variant.
// RULE17 - Signed high doubleword record compares result with zero, copies summary overflow.
// RULE18 - Summary overflow is sticky; overflow flag rewritten on each enabled multiply.
`timescale 1ns/1ps
`default_nettype none
`include "imu_defines.svh"

module imu_integer_multiply_unit #(
  parameter bit IMPL64 = 1'b1,
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Issue from the core pipeline
  input  wire logic              issueValid,
  output logic                   issueReady,
  input  wire logic [31:0]       issueInstr,
  input  wire logic [63:0]       srcAData,
  input  wire logic [63:0]       srcBData,
  // Result to the general register file
  output logic                   resultValid,
  output logic [4:0]             resultDestIdx,
  output logic [63:0]            resultData,
  output logic                   illegalInstr,
  // Architectural state
  output logic [3:0]             condFieldZero,
  output logic [2:0]             fixedExcFlags,
  output logic [31:0]            lowProductData,
  // Interrupt
  output logic                   irq,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // Signed compare against zero, over 32 or 64 bits
  function automatic logic [2:0] cmpZero(input logic [63:0] v, input logic narrow);
    logic neg;
    logic zero;
    neg  = narrow ? v[31] : v[63];
    zero = narrow ? (v[31:0] == 32'h0000_0000) : (v == 64'h0);
    return {neg, ~neg & ~zero, zero};
  endfunction

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Registers
  logic        newerArch_q;
  logic [2:0]  fixExc_q;
  logic [2:0]  fixExc_d;
  logic [3:0]  condZero_q;
  logic [3:0]  condZero_d;
  logic [31:0] lowProd_q;
  logic [1:0]  intStat_q;
  logic [1:0]  intEn_q;
  logic [31:0] opCount_q;
  logic        resultValid_q;
  logic [4:0]  resultDest_q;
  logic [63:0] resultData_q;
  logic        illegal_q;

  // AXI state
  logic              awHeld_q;
  logic [ADDR_W-1:0] awAddr_q;
  logic              wHeld_q;
  logic [31:0]       wData_q;
  logic [3:0]        wStrb_q;
  logic              bValid_q;
  logic [1:0]        bResp_q;
  logic              rValid_q;
  logic [31:0]       rData_q;
  logic [1:0]        rResp_q;

  // Decode
  wire logic [5:0] primOpc   = issueInstr[31:26];
  wire logic [8:0] extOpc    = issueInstr[9:1];
  wire logic       ovfEnable = issueInstr[10];
  wire logic       recordBit = issueInstr[0];
  wire logic       primHit   = (primOpc == `IMU_PRIMARY_OPC); // RULE7
  wire logic       isFull    = primHit && (extOpc == `IMU_XO_FULLWORD); // RULE7
  wire logic       isHighW   = primHit && (extOpc == `IMU_XO_HIGHWORD); // RULE7
  wire logic       isHighD   = primHit && (extOpc == `IMU_XO_HIGHDBL) && !ovfEnable; // RULE8
  wire logic       isHighDU  = primHit && (extOpc == `IMU_XO_HIGHDBLU) && !ovfEnable; // RULE8

  imu_pkg::imu_op_t op;
  assign op = (isFull && !newerArch_q) ? imu_pkg::IMU_OP_FULLWORD :  // RULE6
              (isHighW && newerArch_q) ? imu_pkg::IMU_OP_HIGHWORD :  // RULE16
              (isHighD && IMPL64)      ? imu_pkg::IMU_OP_HIGHDBL :   // RULE13
              (isHighDU && IMPL64)     ? imu_pkg::IMU_OP_HIGHDBLU :  // RULE13
                                         imu_pkg::IMU_OP_NONE;

  assign issueReady = 1'b1;
  wire logic accept  = issueValid && (op != imu_pkg::IMU_OP_NONE);
  wire logic illegal = issueValid && (op == imu_pkg::IMU_OP_NONE);
  wire logic opFull  = accept && (op == imu_pkg::IMU_OP_FULLWORD);
  wire logic opHighW = accept && (op == imu_pkg::IMU_OP_HIGHWORD);
  wire logic opHighD = accept && (op == imu_pkg::IMU_OP_HIGHDBL);
  wire logic opHighU = accept && (op == imu_pkg::IMU_OP_HIGHDBLU);

  // Products
  wire logic signed [63:0]  prodWord = $signed(srcAData[31:0]) * $signed(srcBData[31:0]);
  wire logic signed [127:0] prodDbl  = $signed(srcAData) * $signed(srcBData);
  wire logic [127:0]        prodDblU = {64'h0, srcAData} * {64'h0, srcBData};
  wire logic [31:0]         prodWordLo = prodWord[31:0];
  wire logic [31:0]         prodWordHi = prodWord[63:32];
  wire logic [63:0]         prodDblHi  = prodDbl[127:64];
  wire logic [63:0]         prodDblUHi = prodDblU[127:64];
  wire logic                wordOvf    = (prodWord[63:31] != {33{prodWord[31]}}); // RULE2

  // Destination value; 32-bit results are sign extended
  wire logic [63:0] destValue = (opHighD) ? prodDblHi :                // RULE9
                                (opHighU) ? prodDblUHi :               // RULE10
                                {{32{prodWordHi[31]}}, prodWordHi};    // RULE1 RULE14

  // Value that condition field zero compares against zero
  wire logic [63:0] cmpValue  = opFull ? {{32{prodWordLo[31]}}, prodWordLo} : destValue; // RULE4
  wire logic        cmpNarrow = opFull || opHighW || !IMPL64;
  wire logic [2:0]  cmpBits   = cmpZero(cmpValue, cmpNarrow); // RULE11 RULE15 RULE17

  // Register write decode
  wire logic              wrFire = awHeld_q && wHeld_q && !bValid_q;
  wire logic              wrCtrl = wrFire && (awAddr_q == ADDR_W'(`IMU_CTRL_OFFS));
  wire logic              wrFix  = wrFire && (awAddr_q == ADDR_W'(`IMU_FIXEXC_OFFS));
  wire logic              wrLow  = wrFire && (awAddr_q == ADDR_W'(`IMU_LOWPROD_OFFS));
  wire logic              wrEn   = wrFire && (awAddr_q == ADDR_W'(`IMU_INTEN_OFFS));
  wire logic              wrClr  = wrFire && (awAddr_q == ADDR_W'(`IMU_INTCLR_OFFS));
  wire logic              wrHit  = wrCtrl || wrFix || wrLow || wrEn || wrClr;
  wire logic [31:0]       wrCtrlVal = laneMerge({31'h0, newerArch_q}, wData_q, wStrb_q);
  wire logic [31:0]       wrFixVal  = laneMerge({29'h0, fixExc_q}, wData_q, wStrb_q);
  wire logic [31:0]       wrLowVal  = laneMerge(lowProd_q, wData_q, wStrb_q);
  wire logic [31:0]       wrEnVal   = laneMerge({30'h0, intEn_q}, wData_q, wStrb_q);
  wire logic [31:0]       wrClrVal  = laneMerge(32'h0, wData_q, wStrb_q);

  // Exception flags: software write first, multiply overlay wins
  always_comb begin
    fixExc_d = wrFix ? wrFixVal[2:0] : fixExc_q;
    if (opFull && ovfEnable) begin // RULE5
      fixExc_d[`IMU_FX_OVF_BIT]    = wordOvf; // RULE18
      fixExc_d[`IMU_FX_SUMOVF_BIT] = fixExc_q[`IMU_FX_SUMOVF_BIT] | wordOvf; // RULE2 RULE18
    end
  end

  // Condition field zero: updated only by recording multiplies
  always_comb begin
    condZero_d = condZero_q;
    if (accept && recordBit) begin // RULE5 RULE12
      condZero_d = {cmpBits, fixExc_d[`IMU_FX_SUMOVF_BIT]}; // RULE4 RULE12 RULE15 RULE17
    end
  end

  // Interrupt events and clears; a set in the clear cycle survives
  wire logic [1:0] intEvents = {opFull && ovfEnable && wordOvf, illegal};
  wire logic [1:0] intStat_d = (intStat_q & ~(wrClr ? wrClrVal[1:0] : 2'h0)) | intEvents;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      newerArch_q <= `IMU_CTRL_RST;
      fixExc_q    <= `IMU_FIXEXC_RST;
      condZero_q  <= `IMU_CONDZ_RST;
      intStat_q   <= `IMU_INT_RST;
      intEn_q     <= `IMU_INT_RST;
    end else begin
      newerArch_q <= wrCtrl ? wrCtrlVal[`IMU_CTRL_NEWER_BIT] : newerArch_q;
      fixExc_q    <= fixExc_d; // RULE3
      condZero_q  <= condZero_d;
      intStat_q   <= intStat_d;
      intEn_q     <= wrEn ? wrEnVal[1:0] : intEn_q;
    end
  end

  // Low product register; multiply wins over a software write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lowProd_q <= `IMU_LOWPROD_RST;
      opCount_q <= 32'h0000_0000;
    end else begin
      if (opFull) begin
        lowProd_q <= prodWordLo; // RULE1
      end else if (wrLow) begin
        lowProd_q <= wrLowVal;
      end
      opCount_q <= accept ? opCount_q + 32'h0000_0001 : opCount_q;
    end
  end

  // Result stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resultValid_q <= 1'b0;
      resultDest_q  <= 5'h00;
      resultData_q  <= 64'h0;
      illegal_q     <= 1'b0;
    end else begin
      resultValid_q <= accept;
      illegal_q     <= illegal; // RULE6 RULE13 RULE16
      if (accept) begin
        resultDest_q <= issueInstr[25:21];
        resultData_q <= destValue;
      end
    end
  end

  assign resultValid    = resultValid_q;
  assign resultDestIdx  = resultDest_q;
  assign resultData     = resultData_q;
  assign illegalInstr   = illegal_q;
  assign condFieldZero  = condZero_q;
  assign fixedExcFlags  = fixExc_q;
  assign lowProductData = lowProd_q;
  assign irq            = |(intStat_q & intEn_q);

  // AXI write channels
  assign s_axi_awready = !awHeld_q && !bValid_q;
  assign s_axi_wready  = !wHeld_q && !bValid_q;
  assign s_axi_bvalid  = bValid_q;
  assign s_axi_bresp   = bResp_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHeld_q <= 1'b0;
      awAddr_q <= '0;
      wHeld_q  <= 1'b0;
      wData_q  <= 32'h0000_0000;
      wStrb_q  <= 4'h0;
      bValid_q <= 1'b0;
      bResp_q  <= `IMU_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
      end else if (wrFire) begin
        awHeld_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end else if (wrFire) begin
        wHeld_q <= 1'b0;
      end
      if (wrFire) begin
        bValid_q <= 1'b1;
        bResp_q  <= wrHit ? `IMU_RESP_OKAY : `IMU_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bValid_q <= 1'b0;
      end
    end
  end

  // AXI read channel
  wire logic [ADDR_W-1:0] rdAddr = {s_axi_araddr[ADDR_W-1:2], 2'b00};
  wire logic rdHit = (rdAddr == ADDR_W'(`IMU_CTRL_OFFS))    || (rdAddr == ADDR_W'(`IMU_FIXEXC_OFFS)) ||
                     (rdAddr == ADDR_W'(`IMU_CONDZ_OFFS))   || (rdAddr == ADDR_W'(`IMU_LOWPROD_OFFS)) ||
                     (rdAddr == ADDR_W'(`IMU_INTSTAT_OFFS)) || (rdAddr == ADDR_W'(`IMU_INTEN_OFFS)) ||
                     (rdAddr == ADDR_W'(`IMU_INTCLR_OFFS))  || (rdAddr == ADDR_W'(`IMU_OPCOUNT_OFFS));
  wire logic [31:0] rdValue =
    (rdAddr == ADDR_W'(`IMU_CTRL_OFFS))    ? {31'h0, newerArch_q} :
    (rdAddr == ADDR_W'(`IMU_FIXEXC_OFFS))  ? {29'h0, fixExc_q} :
    (rdAddr == ADDR_W'(`IMU_CONDZ_OFFS))   ? {28'h0, condZero_q} :
    (rdAddr == ADDR_W'(`IMU_LOWPROD_OFFS)) ? lowProd_q :
    (rdAddr == ADDR_W'(`IMU_INTSTAT_OFFS)) ? {30'h0, intStat_q} :
    (rdAddr == ADDR_W'(`IMU_INTEN_OFFS))   ? {30'h0, intEn_q} :
    (rdAddr == ADDR_W'(`IMU_OPCOUNT_OFFS)) ? opCount_q : 32'h0000_0000;

  assign s_axi_arready = !rValid_q;
  assign s_axi_rvalid  = rValid_q;
  assign s_axi_rdata   = rData_q;
  assign s_axi_rresp   = rResp_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rValid_q <= 1'b0;
      rData_q  <= 32'h0000_0000;
      rResp_q  <= `IMU_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        rValid_q <= 1'b1;
        rData_q  <= rdValue;
        rResp_q  <= rdHit ? `IMU_RESP_OKAY : `IMU_RESP_SLVERR;
      end else if (s_axi_rready) begin
        rValid_q <= 1'b0;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  low_product_a: assert property (opFull |=> lowProductData == $past(prodWordLo)) // RULE1
    else $error("low product register not loaded");
  word_dest_a: assert property (opFull |=> resultValid && resultData[31:0] == $past(prodWordHi)) // RULE1
    else $error("full word destination wrong");
  ovf_set_a: assert property (opFull && ovfEnable && wordOvf |=> fixedExcFlags[2:1] == 2'h3) // RULE2
    else $error("overflow flags not set");
  carry_kept_a: assert property (!wrFix |=> $stable(fixedExcFlags[0])) // RULE3
    else $error("carry flag changed by multiply");
  exc_hold_a: assert property (!(opFull && ovfEnable) && !wrFix |=> $stable(fixedExcFlags)) // RULE5
    else $error("exception flags changed without overflow enable");
  cond_hold_a: assert property (!(accept && recordBit) |=> $stable(condFieldZero)) // RULE5
    else $error("condition field changed without record");
  older_only_a: assert property (issueValid && isFull && newerArch_q |=> illegalInstr && !resultValid) // RULE6
    else $error("full word accepted on newer variant");
  newer_only_a: assert property (issueValid && isHighW && !newerArch_q |=> illegalInstr && !resultValid) // RULE16
    else $error("high word accepted on older variant");
  dbl_signed_a: assert property (opHighD |=> resultData == $past(prodDblHi)) // RULE9
    else $error("signed high doubleword wrong");
  dbl_unsigned_a: assert property (opHighU |=> resultData == $past(prodDblUHi)) // RULE10
    else $error("unsigned high doubleword wrong");
  unsigned_cmp_a: assert property (opHighU && recordBit && IMPL64 |=> condFieldZero[3] == resultData[63]) // RULE11
    else $error("unsigned result not compared signed");
  dbl_illegal_a: assert property (issueValid && (isHighD || isHighDU) && !IMPL64 |=> illegalInstr) // RULE13
    else $error("doubleword form accepted on 32-bit build");
  word_high_a: assert property (opHighW |=> resultData == {{32{$past(prodWordHi[31])}}, $past(prodWordHi)}) // RULE14
    else $error("high word result wrong");
  cond_sum_a: assert property (accept && recordBit |=> condFieldZero[0] == fixedExcFlags[2]) // RULE15 RULE17
    else $error("summary overflow not copied");
  sum_sticky_a: assert property (fixedExcFlags[2] && !wrFix |=> fixedExcFlags[2]) // RULE18
    else $error("summary overflow cleared by multiply");

  // Condition bits judged against the stored low product; overflow flag cleared when no overflow
  full_cond_a: assert property (opFull && recordBit |=> condFieldZero[3] == lowProductData[31] && // RULE4
    condFieldZero[1] == (lowProductData == 32'h0000_0000))
    else $error("full word condition wrong");
  ovf_clear_a: assert property (opFull && ovfEnable && !wordOvf |=> !fixedExcFlags[1]) // RULE18
    else $error("overflow flag not rewritten");

endmodule

`default_nettype wire

// ==== hw/imu_pkg.sv ====
// Types shared by the multiply unit
package imu_pkg;

  // Decoded multiply family, one-hot
  typedef enum logic [4:0] {
    IMU_OP_NONE     = 5'h01,
    IMU_OP_FULLWORD = 5'h02,
    IMU_OP_HIGHWORD = 5'h04,
    IMU_OP_HIGHDBL  = 5'h08,
    IMU_OP_HIGHDBLU = 5'h10
  } imu_op_t;

endpackage

// ==== tb/imu_core_model.sv ====
// Issue pipeline and register file model facing the multiply unit
`timescale 1ns/1ps
`default_nettype none

module imu_core_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Issue side
  output logic             issueValid,
  input  wire logic        issueReady,
  output logic [31:0]      issueInstr,
  output logic [63:0]      srcAData,
  output logic [63:0]      srcBData,
  // Writeback side
  input  wire logic        resultValid,
  input  wire logic [4:0]  resultDestIdx,
  input  wire logic [63:0] resultData
);
  logic [63:0] regFile [32];

  initial begin
    issueValid = 1'b0;
    issueInstr = 32'h0000_0000;
    srcAData   = 64'h0;
    srcBData   = 64'h0;
  end

  // One instruction per call, back to back when called in a row
  task send(input logic [31:0] ins, input logic [63:0] a, input logic [63:0] b);
    @(posedge clk);
    issueValid <= 1'b1;
    issueInstr <= ins;
    srcAData   <= a;
    srcBData   <= b;
  endtask

  // Released operand lines do not keep their last value
  task stop();
    @(posedge clk);
    issueValid <= 1'b0;
    issueInstr <= ~issueInstr;
    srcAData   <= ~srcAData;
    srcBData   <= ~srcBData;
  endtask

  always @(posedge clk) begin
    if (!rst && resultValid === 1'b1 && issueReady === 1'b1) begin
      regFile[resultDestIdx] <= resultData;
    end
  end
endmodule

`default_nettype wire

// ==== tb/integer_multiply_unit_bench.sv ====
// Self-checking bench of the multiply unit
`timescale 1ns/1ps
`default_nettype none
`include "imu_defines.svh"

module integer_multiply_unit_bench;
  typedef struct packed {
    logic        ill;
    logic [4:0]  dst;
    logic [63:0] res;
    logic [3:0]  cond;
    logic [2:0]  fx;
    logic [31:0] low;
  } imu_exp_t;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic issueValid, issueReady, resultValid, illegalInstr, irq;
  logic [31:0] issueInstr, lowProductData;
  logic [63:0] srcAData, srcBData, resultData;
  logic [4:0]  resultDestIdx;
  logic [3:0]  condFieldZero;
  logic [2:0]  fixedExcFlags;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  imu_exp_t    expQ[$];
  imu_exp_t    cur;
  logic [3:0]  expCond = 4'h0;
  logic [2:0]  expFx = 3'h0;
  logic [31:0] expLow = 32'h0;
  logic [15:0] lfsr = 16'he9eb;
  logic [4:0]  dstCnt = 5'h00;
  logic        newer = 1'b0;
  int          n_errors = 0;
  int          check_count = 0;
  int          nOps = 0;
  int          i;

  always #2.5 clk = ~clk;

  imu_core_model u_core (.clk(clk), .rst(rst), .issueValid(issueValid), .issueReady(issueReady),
    .issueInstr(issueInstr), .srcAData(srcAData), .srcBData(srcBData), .resultValid(resultValid),
    .resultDestIdx(resultDestIdx), .resultData(resultData));

  imu_integer_multiply_unit #(.IMPL64(1'b1), .ADDR_W(8)) DUT (.clk(clk), .rst(rst),
    .issueValid(issueValid), .issueReady(issueReady), .issueInstr(issueInstr), .srcAData(srcAData),
    .srcBData(srcBData), .resultValid(resultValid), .resultDestIdx(resultDestIdx), .resultData(resultData),
    .illegalInstr(illegalInstr), .condFieldZero(condFieldZero), .fixedExcFlags(fixedExcFlags),
    .lowProductData(lowProductData), .irq(irq), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  function logic [63:0] rnd64();
    int k;
    for (k = 0; k < 4; k++) begin
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      rnd64 = {rnd64[47:0], lfsr};
    end
  endfunction

  task give_verdict();
    $display("Checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task tmo();
    n_errors++;
    $display("[ERR] wait expected answer seen none");
    give_verdict();
  endtask

  task axiWrite(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
    int k;
    logic a, w, dA, dW;
    @(posedge clk);
    s_axi_awaddr <= ad;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    dA = 1'b0;
    dW = 1'b0;
    for (k = 0; k < 50 && !(dA && dW); k++) begin
      #1;
      a = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      @(posedge clk);
      if (a) begin s_axi_awvalid <= 1'b0; dA = 1'b1; end
      if (w) begin s_axi_wvalid <= 1'b0; dW = 1'b1; end
    end
    for (k = 0; k < 50; k++) begin #1; if (s_axi_bvalid) break; @(posedge clk); end
    if (k == 50) tmo();
    chk("write response", er, s_axi_bresp);
    @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask

  task axiRead(input logic [7:0] ad, input logic [31:0] ed, input logic [1:0] er);
    int k;
    @(posedge clk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 50; k++) begin #1; if (s_axi_arready) break; @(posedge clk); end
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    for (k = 0; k < 50; k++) begin #1; if (s_axi_rvalid) break; @(posedge clk); end
    if (k == 50) tmo();
    chk("read data", ed, s_axi_rdata);
    chk("read response", er, s_axi_rresp);
    @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask

  // Notes the expected outcome, then hands the instruction to the core model
  task issue(input logic [5:0] opc, input logic [8:0] xo, input logic oe, input logic rc,
             input logic [63:0] a, input logic [63:0] b);
    logic signed [63:0]  p32;
    logic signed [127:0] p64;
    logic [63:0]         r, cmp;
    logic                ovf;
    imu_exp_t            e;
    p32 = $signed({{32{a[31]}}, a[31:0]}) * $signed({{32{b[31]}}, b[31:0]});
    p64 = $signed({{64{a[63]}}, a}) * $signed({{64{b[63]}}, b});
    ovf = p32 != {{32{p32[31]}}, p32[31:0]};
    r = {{32{p32[63]}}, p32[63:32]};
    e.ill = opc != `IMU_PRIMARY_OPC;
    case (xo)
      `IMU_XO_FULLWORD: if (newer) e.ill = 1'b1;
      `IMU_XO_HIGHWORD: if (!newer) e.ill = 1'b1;
      `IMU_XO_HIGHDBL: begin if (oe) e.ill = 1'b1; r = p64[127:64]; end
      `IMU_XO_HIGHDBLU: begin if (oe) e.ill = 1'b1; p64 = {64'h0, a} * {64'h0, b}; r = p64[127:64]; end
      default: e.ill = 1'b1;
    endcase
    if (!e.ill) begin
      nOps++;
      cmp = r;
      if (xo == `IMU_XO_FULLWORD) begin
        expLow = p32[31:0];
        cmp = {{32{expLow[31]}}, expLow};
        if (oe) expFx = {expFx[2] | ovf, ovf, expFx[0]};
      end
      if (rc) expCond = {cmp[63], !cmp[63] && cmp != 64'h0, cmp == 64'h0, expFx[2]};
    end
    e.dst = dstCnt;
    e.res = r;
    e.cond = expCond;
    e.fx = expFx;
    e.low = expLow;
    expQ.push_back(e);
    u_core.send({opc, dstCnt, 10'h000, oe, xo, rc}, a, b);
    dstCnt = dstCnt + 5'h01;
  endtask

  task drain();
    int k;
    u_core.stop();
    for (k = 0; k < 20 && expQ.size() != 0; k++) @(posedge clk);
    if (expQ.size() != 0) tmo();
  endtask

  always @(posedge clk) begin
    #1;
    if (resultValid === 1'b1 || illegalInstr === 1'b1) begin
      if (expQ.size() == 0) chk("unexpected answer", 64'h0, 64'h1);
      else begin
        cur = expQ.pop_front();
        chk("illegal", cur.ill, illegalInstr);
        chk("valid", !cur.ill, resultValid);
        if (!cur.ill) chk("destination", cur.dst, resultDestIdx);
        if (!cur.ill) chk("result", cur.res, resultData);
        chk("condition", cur.cond, condFieldZero);
        chk("exception", cur.fx, fixedExcFlags);
        chk("low product", cur.low, lowProductData);
      end
    end
  end

  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 8; i++) axiRead(8'(i * 4), 32'h0, `IMU_RESP_OKAY);
    axiRead(8'h20, 32'h0, `IMU_RESP_SLVERR);
    axiWrite(`IMU_CONDZ_OFFS, 32'hf, `IMU_RESP_SLVERR);
    axiRead(`IMU_CONDZ_OFFS, 32'h0, `IMU_RESP_OKAY);
    axiWrite(`IMU_FIXEXC_OFFS, 32'h1, `IMU_RESP_OKAY);
    expFx = 3'h1;
    issue(`IMU_PRIMARY_OPC, `IMU_XO_FULLWORD, 0, 0, 64'h4500, 64'h8000_7000);
    issue(`IMU_PRIMARY_OPC, `IMU_XO_FULLWORD, 0, 1, 64'h4500, 64'h8000_7000);
    issue(`IMU_PRIMARY_OPC, `IMU_XO_FULLWORD, 1, 0, 64'h4500, 64'h8000_7000);
    issue(`IMU_PRIMARY_OPC, `IMU_XO_FULLWORD, 1, 1, 64'h3, 64'h2);
    issue(`IMU_PRIMARY_OPC, `IMU_XO_HIGHWORD, 0, 1, 64'h3, 64'h2);
    issue(6'h07, `IMU_XO_FULLWORD, 0, 1, 64'h3, 64'h2);
    issue(`IMU_PRIMARY_OPC, `IMU_XO_HIGHDBL, 1, 1, 64'h3, 64'h2);
    issue(`IMU_PRIMARY_OPC, `IMU_XO_HIGHDBLU, 0, 1, '1, '1);
    for (i = 0; i < 12; i++) begin
      issue(`IMU_PRIMARY_OPC, i[0] ? `IMU_XO_HIGHDBL : `IMU_XO_HIGHDBLU, 0, i[1], rnd64(), rnd64());
    end
    drain();
    axiRead(`IMU_INTSTAT_OFFS, 32'h3, `IMU_RESP_OKAY);
    #1;
    chk("irq", 1'b0, irq);
    axiWrite(`IMU_INTEN_OFFS, 32'h1, `IMU_RESP_OKAY);
    #1;
    chk("irq", 1'b1, irq);
    axiWrite(`IMU_INTCLR_OFFS, 32'h1, `IMU_RESP_OKAY);
    #1;
    chk("irq", 1'b0, irq);
    axiRead(`IMU_INTSTAT_OFFS, 32'h2, `IMU_RESP_OKAY);
    axiWrite(`IMU_CTRL_OFFS, 32'h1, `IMU_RESP_OKAY);
    newer = 1'b1;
    issue(`IMU_PRIMARY_OPC, `IMU_XO_FULLWORD, 0, 1, 64'h5, 64'h7);
    issue(`IMU_PRIMARY_OPC, `IMU_XO_HIGHWORD, 0, 1, 64'h4500, 64'h8000_7000);
    for (i = 0; i < 4; i++) issue(`IMU_PRIMARY_OPC, `IMU_XO_HIGHWORD, 0, i[0], rnd64(), rnd64());
    drain();
    axiRead(`IMU_LOWPROD_OFFS, expLow, `IMU_RESP_OKAY);
    axiRead(`IMU_FIXEXC_OFFS, {29'h0, expFx}, `IMU_RESP_OKAY);
    axiRead(`IMU_OPCOUNT_OFFS, nOps, `IMU_RESP_OKAY);
    give_verdict();
  end
endmodule

`default_nettype wire
